// ### hw/bsns_core.sv
// Execution datapath for borrow-subtract and nibble-exchange instructions
`timescale 1ns/100ps
`include "bsns_defines.svh"
module bsns_core (
    // Clock and reset
    input  wire logic        clk_in,
    input  wire logic        nrst_in,
    // Instruction from the decoder
    input  wire logic        instr_valid_in,
    input  wire logic [15:0] instr_in,
    // Operand values
    input  wire logic [7:0]  file_data_in,
    input  wire logic [7:0]  acc_in,
    input  wire logic        carry_in,
    input  wire logic [7:0]  bank_pointer_reg_in,
    // File register read address (combinational)
    output logic      [15:0] file_raddr_out,
    // File register write-back
    output logic             file_we_out,
    output logic      [15:0] file_waddr_out,
    output logic      [7:0]  file_wdata_out,
    // Accumulator write
    output logic             acc_we_out,
    output logic      [7:0]  acc_wdata_out,
    // Status flag update
    output logic             flags_we_out,
    output logic             flag_c_out,
    output logic             flag_z_out,
    output logic             flag_n_out,
    output logic             flag_ov_out
);
    // Decoded instruction fields
    bsns_pkg::bsns_op_t op;
    logic [5:0]         opc;
    logic               dest;
    logic               bank_sel;
    logic [7:0]         fsel;
    logic [7:0]         bank_hi;
    logic [15:0]        addr;
    logic               is_swap;
    logic               is_subb;
    logic               to_acc;
    logic               to_file;

    // Arithmetic results
    logic [7:0]         result;
    logic               carry_res;
    logic               ovf_res;

    // File register write-back state
    logic               file_we_r;
    logic               file_we_nxt;
    logic [15:0]        file_waddr_r;
    logic [15:0]        file_waddr_nxt;
    logic [7:0]         file_wdata_r;
    logic [7:0]         file_wdata_nxt;

    // Accumulator write state
    logic               acc_we_r;
    logic               acc_we_nxt;
    logic [7:0]         acc_wdata_r;
    logic [7:0]         acc_wdata_nxt;

    // Status flag state
    logic               flags_we_r;
    logic               flags_we_nxt;
    logic               c_r;
    logic               c_nxt;
    logic               z_r;
    logic               z_nxt;
    logic               n_r;
    logic               n_nxt;
    logic               ov_r;
    logic               ov_nxt;

    // Field extraction and opcode match
    always_comb begin
        opc      = instr_in[`BSNS_OPC_MSB:`BSNS_OPC_LSB];
        dest     = instr_in[`BSNS_DEST_BIT];
        bank_sel = instr_in[`BSNS_BANK_BIT];
        fsel     = instr_in[`BSNS_ADDR_MSB:`BSNS_ADDR_LSB];
        is_swap  = instr_valid_in && (opc == `BSNS_OPC_SWAP);
        is_subb  = instr_valid_in && (opc == `BSNS_OPC_SUBB);
        op       = bsns_pkg::BSNS_OP_NONE;
        if (is_swap) begin
            op = bsns_pkg::BSNS_OP_SWAP;
        end else if (is_subb) begin
            op = bsns_pkg::BSNS_OP_SUBB;
        end
        to_acc  = (is_swap || is_subb) && (dest == `BSNS_DEST_ACC);
        to_file = (is_swap || is_subb) && (dest == `BSNS_DEST_FILE);
    end

    // Access bank maps to bank 0; banked accesses use the pointer
    always_comb begin
        bank_hi = `BSNS_BYTE_ZERO;
        if (bank_sel != `BSNS_ACCESS_BANK) begin
            bank_hi = bank_pointer_reg_in;
        end
        addr           = {bank_hi, fsel};
        file_raddr_out = addr;
    end

    bsns_alu u_alu (
        .op_in      (op),
        .file_in    (file_data_in),
        .acc_in     (acc_in),
        .carry_in   (carry_in),
        .result_out (result),
        .carry_out  (carry_res),
        .ovf_out    (ovf_res)
    );

    // File register write-back: strobe pulses, address and data hold
    always_comb begin
        file_we_nxt    = 1'h0;
        file_waddr_nxt = file_waddr_r;
        file_wdata_nxt = file_wdata_r;
        if (to_file) begin
            file_we_nxt    = 1'h1;
            file_waddr_nxt = addr;
            file_wdata_nxt = result;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            file_we_r    <= 1'h0;
            file_waddr_r <= `BSNS_ADDR_ZERO;
            file_wdata_r <= `BSNS_BYTE_ZERO;
        end else begin
            file_we_r    <= file_we_nxt;
            file_waddr_r <= file_waddr_nxt;
            file_wdata_r <= file_wdata_nxt;
        end
    end

    // Accumulator write: file register is left untouched
    always_comb begin
        acc_we_nxt    = 1'h0;
        acc_wdata_nxt = acc_wdata_r;
        if (to_acc) begin
            acc_we_nxt    = 1'h1;
            acc_wdata_nxt = result;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            acc_we_r    <= 1'h0;
            acc_wdata_r <= `BSNS_BYTE_ZERO;
        end else begin
            acc_we_r    <= acc_we_nxt;
            acc_wdata_r <= acc_wdata_nxt;
        end
    end

    // Status flags: only the subtract updates them
    always_comb begin
        flags_we_nxt = 1'h0;
        c_nxt        = c_r;
        z_nxt        = z_r;
        n_nxt        = n_r;
        ov_nxt       = ov_r;
        case (op)
            bsns_pkg::BSNS_OP_SUBB: begin
                flags_we_nxt = 1'h1;
                c_nxt        = carry_res;
                z_nxt        = (result == `BSNS_BYTE_ZERO);
                n_nxt        = result[7];
                ov_nxt       = ovf_res;
            end
            bsns_pkg::BSNS_OP_SWAP: begin
                // Exchange leaves every flag as it was
                flags_we_nxt = 1'h0;
            end
            default: begin
                flags_we_nxt = 1'h0;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            flags_we_r <= 1'h0;
            c_r        <= 1'h0;
            z_r        <= 1'h0;
            n_r        <= 1'h0;
            ov_r       <= 1'h0;
        end else begin
            flags_we_r <= flags_we_nxt;
            c_r        <= c_nxt;
            z_r        <= z_nxt;
            n_r        <= n_nxt;
            ov_r       <= ov_nxt;
        end
    end

    assign file_we_out    = file_we_r;
    assign file_waddr_out = file_waddr_r;
    assign file_wdata_out = file_wdata_r;
    assign acc_we_out     = acc_we_r;
    assign acc_wdata_out  = acc_wdata_r;
    assign flags_we_out   = flags_we_r;
    assign flag_c_out     = c_r;
    assign flag_z_out     = z_r;
    assign flag_n_out     = n_r;
    assign flag_ov_out    = ov_r;
endmodule : bsns_core

// ### hw/bsns_defines.svh
// Constants for the borrow-subtract and nibble-exchange datapath
`ifndef BSNS_DEFINES_SVH
`define BSNS_DEFINES_SVH
`define BSNS_OPC_SUBB     6'h15
`define BSNS_OPC_SWAP     6'h0E
`define BSNS_OPC_MSB      15
`define BSNS_OPC_LSB      10
`define BSNS_DEST_BIT     9
`define BSNS_BANK_BIT     8
`define BSNS_ADDR_MSB     7
`define BSNS_ADDR_LSB     0
`define BSNS_ADDR_ZERO    16'h0000
`define BSNS_DEST_ACC     1'h0
`define BSNS_DEST_FILE    1'h1
`define BSNS_BYTE_ZERO    8'h00
`define BSNS_ACCESS_BANK  1'h0
`endif

// ### hw/bsns_pkg.sv
// Types for the borrow-subtract and nibble-exchange datapath
package bsns_pkg;
    typedef enum logic [1:0] {
        BSNS_OP_NONE,
        BSNS_OP_SUBB,
        BSNS_OP_SWAP
    } bsns_op_t;
endpackage : bsns_pkg

// ### hw/bsns_alu.sv
// Combinational arithmetic for both operations
`timescale 1ns/100ps
`include "bsns_defines.svh"
module bsns_alu (
    // Operation and operands
    input  wire bsns_pkg::bsns_op_t op_in,
    input  wire logic [7:0]         file_in,
    input  wire logic [7:0]         acc_in,
    input  wire logic               carry_in,
    // Result and flags
    output logic      [7:0]         result_out,
    output logic                    carry_out,
    output logic                    ovf_out
);
    logic [8:0] diff;
    always_comb begin
        // Borrow is the inverted carry
        diff       = {1'h0, file_in} + {1'h0, ~acc_in} + {`BSNS_BYTE_ZERO, carry_in};
        result_out = `BSNS_BYTE_ZERO;
        carry_out  = 1'h0;
        ovf_out    = 1'h0;
        case (op_in)
            bsns_pkg::BSNS_OP_SUBB: begin
                result_out = diff[7:0];
                carry_out  = diff[8];
                ovf_out    = (file_in[7] != acc_in[7]) && (diff[7] != file_in[7]);
            end
            bsns_pkg::BSNS_OP_SWAP: begin
                result_out = {file_in[3:0], file_in[7:4]};
            end
            default: begin
                result_out = `BSNS_BYTE_ZERO;
            end
        endcase
    end
endmodule : bsns_alu

// ### tb/bsns_core_sva.sv
// Checker for the borrow-subtract and nibble-exchange datapath
`timescale 1ns/100ps
`include "bsns_defines.svh"
module bsns_core_sva (
    // Clock, reset and request
    input wire logic        clk_in,
    input wire logic        nrst_in,
    input wire logic        instr_valid_in,
    input wire logic [15:0] instr_in,
    input wire logic [7:0]  file_data_in,
    input wire logic [7:0]  acc_in,
    input wire logic        carry_in,
    // Results
    input wire logic        file_we_out,
    input wire logic [7:0]  file_wdata_out,
    input wire logic        acc_we_out,
    input wire logic [7:0]  acc_wdata_out,
    input wire logic        flags_we_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    logic sub_take;
    logic swp_take;
    logic [7:0] res;
    assign sub_take = instr_valid_in && instr_in[15:10] == `BSNS_OPC_SUBB;
    assign swp_take = instr_valid_in && instr_in[15:10] == `BSNS_OPC_SWAP;
    assign res = file_we_out ? file_wdata_out : acc_wdata_out;
    a_sub_result: assert property (sub_take |=> flags_we_out && res == 8'($past(file_data_in)
        - $past(acc_in) - {7'h00, ~$past(carry_in)})) else $error("bad difference");
    a_dest_acc: assert property ((sub_take || swp_take) && !instr_in[9] |=> acc_we_out
        && !file_we_out) else $error("bad acc write");
    a_dest_file: assert property ((sub_take || swp_take) && instr_in[9] |=> file_we_out
        && !acc_we_out) else $error("bad file write");
    a_decode_only: assert property (!(sub_take || swp_take) |=> !(file_we_out || acc_we_out
        || flags_we_out)) else $error("strobe without instruction");
    a_swap_nibbles: assert property (swp_take |=> !flags_we_out
        && res == {$past(file_data_in[3:0]), $past(file_data_in[7:4])}) else $error("bad swap");
endmodule : bsns_core_sva
bind bsns_core bsns_core_sva u_bsns_core_sva (.clk_in, .nrst_in, .instr_valid_in, .instr_in,
    .file_data_in, .acc_in, .carry_in, .file_we_out, .file_wdata_out, .acc_we_out,
    .acc_wdata_out, .flags_we_out);

// ### tb/bsns_file_model.sv
// File register array on the far side of the datapath
`timescale 1ns/100ps
module bsns_file_model (
    // Clock
    input  wire logic        clk_in,
    // Read and write ports
    input  wire logic [15:0] raddr_in,
    input  wire logic        we_in,
    input  wire logic [15:0] waddr_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out
);
    logic [7:0] mem [0:65535];
    assign rdata_out = mem[raddr_in];
    always @(posedge clk_in) if (we_in) mem[waddr_in] <= wdata_in;
endmodule : bsns_file_model

// ### tb/bsns_core_tb.sv
// Testbench for the borrow-subtract and nibble-exchange datapath
`timescale 1ns/100ps
module bsns_core_tb;
    logic        clk_in, nrst_in, vld, cy, fwe, awe, gwe;
    logic [15:0] ins, ra, wa;
    logic [7:0]  fd, acc, bank, wd, ad;
    logic [3:0]  fl;
    logic [31:0] tbl [3] = '{32'h190D0C83, 32'h1B1A00C0, 32'h030EF523};
    int          fails, checks;
    bsns_core u_bsns_core (.clk_in, .nrst_in, .instr_valid_in(vld), .instr_in(ins),
        .file_data_in(fd), .acc_in(acc), .carry_in(cy), .bank_pointer_reg_in(bank),
        .file_raddr_out(ra), .file_we_out(fwe), .file_waddr_out(wa), .file_wdata_out(wd),
        .acc_we_out(awe), .acc_wdata_out(ad), .flags_we_out(gwe), .flag_c_out(fl[3]),
        .flag_z_out(fl[2]), .flag_n_out(fl[1]), .flag_ov_out(fl[0]));
    bsns_file_model u_bsns_file_model (.clk_in, .raddr_in(ra), .we_in(fwe), .waddr_in(wa),
        .wdata_in(wd), .rdata_out(fd));
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic run(input logic [15:0] op, input logic [7:0] a, input logic c, v);
        @(posedge clk_in);
        #1;
        {ins, acc, cy, vld} = {op, a, c, v};
        @(posedge clk_in);
        #1;
        vld = 1'b0;
    endtask : run
    task automatic t_swap;
        u_bsns_file_model.mem[16'h0012] = 8'h53;
        u_bsns_file_model.mem[16'h0212] = 8'hA7;
        bank = 8'h02;
        run(16'h3A12, 8'h00, 1'b0, 1'b1);
        check("swap strobes", {fwe, awe, gwe, wa}, {3'b100, 16'h0012});
        check("swap data", wd, 8'h35);
        run(16'h3912, 8'h00, 1'b0, 1'b1);
        check("swap acc", {fwe, awe, gwe, ad}, {3'b010, 8'h7A});
        check("read addr", ra, 16'h0212);
        run(16'h5812, 8'h01, 1'b1, 1'b1);
        check("other op", {fwe, awe, gwe}, 3'b000);
        run(16'h3A12, 8'h00, 1'b0, 1'b0);
        check("idle", {fwe, awe, gwe}, 3'b000);
        check("file kept", u_bsns_file_model.mem[16'h0212], 8'hA7);
        check("file swapped", u_bsns_file_model.mem[16'h0012], 8'h35);
    endtask : t_swap
    task automatic t_sub;
        logic [31:0] r;
        for (int i = 0; i < 3; i++) begin
            r = tbl[i];
            u_bsns_file_model.mem[16'h0020 + i] = r[31:24];
            run({6'h15, r[0], 1'b0, 8'(8'h20 + i)}, r[23:16], r[1], 1'b1);
            check("sub strobes", {fwe, awe, gwe}, {r[0], ~r[0], 1'b1});
            check("sub result", r[0] ? wd : ad, r[15:8]);
            check("sub flags", fl, r[7:4]);
        end
        run(16'h3A20, 8'h00, 1'b0, 1'b1);
        check("swap after sub", wd, 8'hC0);
        check("swap keeps flags", {gwe, fl}, {1'h0, 4'h2});
    endtask : t_sub
    task automatic complete_run;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : complete_run
    initial begin
        {clk_in, nrst_in, vld, cy, ins, acc, bank, fails, checks} = '0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        repeat (4) @(posedge clk_in);
        #1;
        nrst_in = 1'b1;
        t_swap;
        t_sub;
        complete_run;
    end
    initial begin
        #2000;
        fails++;
        complete_run;
    end
endmodule : bsns_core_tb
